// ### bench/tcc_block_monitor.sv
`timescale 1ns/100ps
// port-level checks of the compare/capture register block
module tcc_block_monitor #(
   parameter int NUM_TIMERS = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire tcc_pkg::tcc_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic global_irq_enable,
   input wire tcc_pkg::tcc_timer_in_t [NUM_TIMERS-1:0] timer_in,
   input wire logic [NUM_TIMERS-1:0][2:0] force_strobe,
   input wire logic [NUM_TIMERS-1:0][2:0] waveform_output_pin,
   input wire logic [NUM_TIMERS-1:0][5:0] irq_request,
   input wire logic [NUM_TIMERS-1:0] count_load,
   input wire logic [15:0] count_load_word
);
   import tcc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // no request may stand once the global enable has been seen low
   a_req_global: assert property (
      !global_irq_enable |=> irq_request == '0)
      else $error("request without global enable");
   a_force_toggle: assert property (
      $rose(force_strobe[1][1]) |-> ##[1:2] $changed(waveform_output_pin[1][1]))
      else $error("force strobe did not toggle waveform");
   a_wave_still: assert property (
      !timer_in[1].tick && !$past(timer_in[1].tick) && !force_strobe[1][1]
      && !$past(force_strobe[1][1]) |=> $stable(waveform_output_pin[1][1]))
      else $error("waveform moved without cause");
   a_load_low: assert property (
      bus.wr && bus.addr == TCC_COUNT_VALUE_OFS[0] |=>
      count_load[0] && count_load_word[7:0] == $past(bus.wdata))
      else $error("counter write not passed on");
   a_load_cause: assert property (
      count_load[0] |-> $past(bus.wr) && $past(bus.addr) == 9'h084)
      else $error("counter load without write");
   // read data stands from the edge after the read until the next read
   a_enable_reserved: assert property (
      bus.rd && bus.addr == TCC_IRQ_ENABLES_OFS[1] |-> ##2
      (rdata & ~TCC_FLAG_MASK) == 8'h00)
      else $error("enable reserved bits set");
   a_flag_reserved: assert property (
      bus.rd && bus.addr == TCC_EVENT_FLAGS_OFS[0] |-> ##2
      (rdata & ~TCC_FLAG_MASK) == 8'h00)
      else $error("flag reserved bits set");
   a_unmapped_zero: assert property (
      bus.rd && bus.addr == 9'h000 |-> ##2 rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (
      !bus.rd && !$past(bus.rd) |=> $stable(rdata))
      else $error("read data changed without read");
endmodule
bind tcc_block tcc_block_monitor #(.NUM_TIMERS(NUM_TIMERS)) u_mon (
   .core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
   .global_irq_enable(global_irq_enable), .timer_in(timer_in),
   .force_strobe(force_strobe), .waveform_output_pin(waveform_output_pin),
   .irq_request(irq_request), .count_load(count_load),
   .count_load_word(count_load_word));

// ### bench/tcc_cpu_model.sv
`timescale 1ns/100ps
// cpu byte bus master; strobes last one cycle, address scrambled when idle
module tcc_cpu_model (
   input wire logic core_clk,
   output tcc_pkg::tcc_bus_t bus,
   input wire logic [7:0] rdata
);
   import tcc_pkg::*;
   initial bus = '0;
   // an idle cycle between accesses keeps each strobe a clean pulse
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge core_clk);
      bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge core_clk);
      bus = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask
   // read data is registered at the taking edge, picked up just after it
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(negedge core_clk);
      bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge core_clk);
      d = rdata;
      bus = '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
   endtask
   // high byte first so the shared byte is staged before the low write
   task automatic wr16(input logic [8:0] a, input logic [15:0] v);
      wr(a + 9'h001, v[15:8]);
      wr(a, v[7:0]);
   endtask
endmodule

// ### bench/timer16_compare_capture_irq_tb_top.sv
`timescale 1ns/100ps
module timer16_compare_capture_irq_tb_top;
   import tcc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic global_irq_enable = 1'b0;
   tcc_bus_t bus;
   logic [7:0] rdata;
   tcc_timer_in_t [3:0] timer_in = '0;
   logic [3:0][2:0] force_strobe = '0;
   logic [3:0][5:0] irq_ack = '0;
   logic [3:0][5:0] irq_request;
   logic [3:0][2:0] waveform_output_pin;
   logic [3:0] count_load;
   logic [15:0] count_load_word;
   int fails = 0;
   int samples_checked = 0;
   logic w;
   always #2.5 core_clk = ~core_clk;
   tcc_block #(.NUM_TIMERS(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .bus(bus), .rdata(rdata), .global_irq_enable(global_irq_enable),
      .timer_in(timer_in), .force_strobe(force_strobe), .irq_ack(irq_ack),
      .irq_request(irq_request), .waveform_output_pin(waveform_output_pin),
      .count_load(count_load), .count_load_word(count_load_word));
   tcc_cpu_model cpu (.core_clk(core_clk), .bus(bus), .rdata(rdata));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_reg(input string n, input logic [8:0] a,
      input logic [7:0] e);
      logic [7:0] d;
      cpu.rd(a, d);
      chk(n, e, d);
   endtask
   // one-cycle counter event; m is {tick, capture, top, overflow, written}
   task automatic ev(input int t, input logic [15:0] v, input logic [4:0] m);
      @(negedge core_clk);
      timer_in[t] = {v, m};
      @(negedge core_clk);
      timer_in[t] = {v, 5'h00};
   endtask
   task automatic end_sim;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // the tick after the matching one is the one that shows the flag
   task automatic t_match;
      logic [15:0] v;
      for (int c = 0; c < 3; c++) begin
         v = 16'h5ac0 + 16'(c);
         cpu.wr16(c == 0 ? TCC_COMPARE_A_OFS[3] : c == 1 ?
            TCC_COMPARE_B_OFS[3] : TCC_COMPARE_C_OFS[3], v);
         ev(3, v ^ 16'h0100, 5'h10);
         ev(3, v, 5'h10);
         chk_reg("flag early", TCC_EVENT_FLAGS_OFS[3], 8'h00);
         ev(3, v + 16'h0001, 5'h10);
         chk_reg("flag set", TCC_EVENT_FLAGS_OFS[3], 8'h02 << c);
         chk("wave match", 8'h01, {7'h00, waveform_output_pin[3][c]});
         cpu.wr(TCC_EVENT_FLAGS_OFS[3], 8'h00);
         chk_reg("w1c zero", TCC_EVENT_FLAGS_OFS[3], 8'h02 << c);
         cpu.wr(TCC_EVENT_FLAGS_OFS[3], 8'h02 << c);
         chk_reg("w1c one", TCC_EVENT_FLAGS_OFS[3], 8'h00);
      end
      $display("t_match done");
   endtask
   // reset values, and enables keep only their defined bits
   task automatic t_regs;
      for (int t = 0; t < 4; t++) begin
         chk_reg("flags rst", TCC_EVENT_FLAGS_OFS[t], 8'h00);
         chk_reg("capture rst", TCC_CAPTURE_VALUE_OFS[t], 8'h00);
         cpu.wr(TCC_IRQ_ENABLES_OFS[t], 8'hff);
         chk_reg("enables", TCC_IRQ_ENABLES_OFS[t], 8'h2f);
         cpu.wr(TCC_IRQ_ENABLES_OFS[t], 8'h00);
      end
      chk_reg("unmapped", 9'h000, 8'h00);
      $display("t_regs done");
   endtask
   // a capture between the two byte reads must not tear the word
   task automatic t_capture;
      ev(0, 16'h1234, 5'h08);
      chk_reg("capture low", TCC_CAPTURE_VALUE_OFS[0], 8'h34);
      ev(0, 16'h5678, 5'h08);
      chk_reg("capture high", TCC_CAPTURE_VALUE_OFS[0] + 9'h001, 8'h12);
      chk_reg("capture flag", TCC_EVENT_FLAGS_OFS[0], 8'h20);
      @(negedge core_clk);
      irq_ack[0][5] = 1'b1;
      @(negedge core_clk);
      irq_ack[0][5] = 1'b0;
      chk_reg("ack clear", TCC_EVENT_FLAGS_OFS[0], 8'h00);
      // capture value as top: the flag comes only when the count reaches it
      ev(0, 16'h5677, 5'h14);
      chk_reg("top early", TCC_EVENT_FLAGS_OFS[0], 8'h00);
      ev(0, 16'h5678, 5'h14);
      chk_reg("top flag", TCC_EVENT_FLAGS_OFS[0], 8'h20);
      cpu.wr(TCC_EVENT_FLAGS_OFS[0], 8'h20);
      $display("t_capture done");
   endtask
   // counter write hides the match on the next tick only
   task automatic t_suppress;
      cpu.wr16(TCC_COMPARE_A_OFS[0], 16'h0040);
      cpu.wr16(TCC_COUNT_VALUE_OFS[0], 16'h0040);
      ev(0, 16'h0040, 5'h01);
      ev(0, 16'h0040, 5'h10);
      ev(0, 16'h0041, 5'h10);
      chk_reg("suppressed", TCC_EVENT_FLAGS_OFS[0], 8'h00);
      ev(0, 16'h0040, 5'h10);
      ev(0, 16'h0041, 5'h10);
      chk_reg("match a", TCC_EVENT_FLAGS_OFS[0], 8'h02);
      $display("t_suppress done");
   endtask
   // request needs enable, global enable and flag together
   task automatic t_irq;
      cpu.wr(TCC_IRQ_ENABLES_OFS[1], 8'h01);
      global_irq_enable = 1'b1;
      ev(1, 16'h0000, 5'h02);
      chk_reg("overflow", TCC_EVENT_FLAGS_OFS[1], 8'h01);
      chk("request", 8'h01, {7'h00, irq_request[1][0]});
      global_irq_enable = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("masked", 8'h00, {7'h00, irq_request[1][0]});
      global_irq_enable = 1'b1;
      cpu.wr(TCC_EVENT_FLAGS_OFS[1], 8'h01);
      chk_reg("ovf clear", TCC_EVENT_FLAGS_OFS[1], 8'h00);
      chk("req drop", 8'h00, {7'h00, irq_request[1][0]});
      $display("t_irq done");
   endtask
   // forced strobes move the pins and leave the flags alone
   task automatic t_force;
      for (int b = 1; b < 3; b++) begin
         w = waveform_output_pin[1][b];
         force_strobe[1][b] = 1'b1;
         @(negedge core_clk);
         force_strobe[1][b] = 1'b0;
         repeat (2) @(negedge core_clk);
         chk("toggle", {7'h00, ~w}, {7'h00, waveform_output_pin[1][b]});
      end
      chk_reg("no flag", TCC_EVENT_FLAGS_OFS[1], 8'h00);
      $display("t_force done");
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      t_regs();
      t_match();
      t_capture();
      t_suppress();
      t_irq();
      t_force();
      end_sim();
   end
   // hang guard
   initial begin
      #200000;
      fails++;
      end_sim();
   end
endmodule

// ### include/tcc_pkg.sv
package tcc_pkg;
   // data-space byte addresses of the register file
   localparam logic [8:0] TCC_EVENT_FLAGS_OFS [4] = '{
      9'h036, 9'h038, 9'h039, 9'h03a};
   localparam logic [8:0] TCC_IRQ_ENABLES_OFS [4] = '{
      9'h06f, 9'h071, 9'h072, 9'h073};
   localparam logic [8:0] TCC_CAPTURE_VALUE_OFS [4] = '{
      9'h086, 9'h096, 9'h0a6, 9'h126};
   localparam logic [8:0] TCC_COUNT_VALUE_OFS [4] = '{
      9'h084, 9'h094, 9'h0a4, 9'h124};
   localparam logic [8:0] TCC_COMPARE_A_OFS [4] = '{
      9'h088, 9'h098, 9'h0a8, 9'h128};
   localparam logic [8:0] TCC_COMPARE_B_OFS [4] = '{
      9'h08a, 9'h09a, 9'h0aa, 9'h12a};
   localparam logic [8:0] TCC_COMPARE_C_OFS [4] = '{
      9'h08c, 9'h09c, 9'h0ac, 9'h12c};
   // flag and enable bit positions
   localparam int TCC_BIT_OVERFLOW = 0;
   localparam int TCC_BIT_COMPARE_A = 1;
   localparam int TCC_BIT_COMPARE_B = 2;
   localparam int TCC_BIT_COMPARE_C = 3;
   localparam int TCC_BIT_CAPTURE = 5;
   localparam logic [7:0] TCC_FLAG_MASK = 8'h2f;
   localparam logic [7:0] TCC_BYTE_RESET = 8'h00;
   localparam logic [15:0] TCC_WORD_RESET = 16'h0000;
   localparam logic [15:0] TCC_COUNT_MAX = 16'hffff;

   // one timer's view of its counter and mode
   typedef struct packed {
      logic [15:0] count;
      logic tick;
      logic capture_event;
      logic capture_is_top;
      logic overflow_event;
      logic count_written;
   } tcc_timer_in_t;

   // cpu byte bus
   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcc_bus_t;
endpackage

// ### rtl/tcc_block.sv
`timescale 1ns/100ps
module tcc_block #(
   parameter int NUM_TIMERS = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire tcc_pkg::tcc_bus_t bus,
   output logic [7:0] rdata,
   input wire logic global_irq_enable,
   input wire tcc_pkg::tcc_timer_in_t [NUM_TIMERS-1:0] timer_in,
   input wire logic [NUM_TIMERS-1:0][2:0] force_strobe,
   input wire logic [NUM_TIMERS-1:0][5:0] irq_ack,
   output logic [NUM_TIMERS-1:0][5:0] irq_request,
   output logic [NUM_TIMERS-1:0][2:0] waveform_output_pin,
   output logic [NUM_TIMERS-1:0] count_load,
   output logic [15:0] count_load_word
);
   import tcc_pkg::*;

   // the register map is fixed at four timers; refuse anything else
   if (NUM_TIMERS != 4) begin : gen_bad_count
      $error("tcc_block serves exactly four timers");
   end

   logic [7:0] temp_reg;
   logic [7:0] flags_reg [NUM_TIMERS];
   logic [7:0] enables_reg [NUM_TIMERS];
   logic [15:0] cmp_a [NUM_TIMERS];
   logic [15:0] cmp_b [NUM_TIMERS];
   logic [15:0] cmp_c [NUM_TIMERS];
   logic [15:0] cap [NUM_TIMERS];
   logic [5:0] flag_set [NUM_TIMERS];
   logic [2:0] wave_toggle [NUM_TIMERS];
   logic [2:0] cmp_load [NUM_TIMERS];
   logic cap_load [NUM_TIMERS];
   logic [15:0] load_word;
   logic [7:0] rdata_next;
   logic [7:0] temp_next;
   logic temp_load;
   logic temp_stage;

   // low-byte write forms the word from the staged high byte
   assign load_word = {temp_reg, bus.wdata};

   genvar g;
   generate
      for (g = 0; g < NUM_TIMERS; g++) begin : gen_timer
         // word stores take effect on the low-byte write only
         always_comb begin
            cmp_load[g][0] = bus.wr && bus.addr == TCC_COMPARE_A_OFS[g];
            cmp_load[g][1] = bus.wr && bus.addr == TCC_COMPARE_B_OFS[g];
            cmp_load[g][2] = bus.wr && bus.addr == TCC_COMPARE_C_OFS[g];
            cap_load[g] = bus.wr && bus.addr == TCC_CAPTURE_VALUE_OFS[g];
         end

         tcc_channel u_chan (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .tin(timer_in[g]),
            .cmp_load(cmp_load[g]),
            .cap_load(cap_load[g]),
            .load_word(load_word),
            .force_strobe(force_strobe[g]),
            .cmp_a(cmp_a[g]),
            .cmp_b(cmp_b[g]),
            .cmp_c(cmp_c[g]),
            .cap(cap[g]),
            .flag_set(flag_set[g]),
            .wave_toggle(wave_toggle[g])
         );

         // clear mask: vector acknowledge or a one written to the flag bit
         logic [7:0] flag_clear;
         always_comb begin
            flag_clear = {2'b00, irq_ack[g]};
            if (bus.wr && bus.addr == TCC_EVENT_FLAGS_OFS[g]) begin
               flag_clear = flag_clear | bus.wdata;
            end
         end

         // sticky flags: a set in the clear cycle wins
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               flags_reg[g] <= TCC_BYTE_RESET;
            end else begin
               flags_reg[g] <= ((flags_reg[g] & ~flag_clear)
                  | {2'b00, flag_set[g]}) & TCC_FLAG_MASK;
            end
         end

         // enable register, unused bits held at zero
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               enables_reg[g] <= TCC_BYTE_RESET;
            end else if (bus.wr && bus.addr == TCC_IRQ_ENABLES_OFS[g]) begin
               enables_reg[g] <= bus.wdata & TCC_FLAG_MASK;
            end
         end

         // request needs all three conditions
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               irq_request[g] <= 6'h00;
            end else begin
               irq_request[g] <= enables_reg[g][5:0] & flags_reg[g][5:0]
                  & {6{global_irq_enable}};
            end
         end

         // waveform pins toggle on match or forced strobe
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               waveform_output_pin[g] <= 3'h0;
            end else begin
               waveform_output_pin[g] <= waveform_output_pin[g]
                  ^ wave_toggle[g];
            end
         end

         // counter itself lives outside; forward the coherent word
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               count_load[g] <= 1'b0;
            end else begin
               count_load[g] <= bus.wr
                  && bus.addr == TCC_COUNT_VALUE_OFS[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count_load_word <= TCC_WORD_RESET;
      end else begin
         count_load_word <= load_word;
      end
   end

   // read decode; capture and count low-byte reads also stage the high byte
   always_comb begin
      rdata_next = TCC_BYTE_RESET;
      temp_next = temp_reg;
      temp_load = 1'b0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         if (bus.addr == TCC_EVENT_FLAGS_OFS[i]) begin
            rdata_next = flags_reg[i];
         end else if (bus.addr == TCC_IRQ_ENABLES_OFS[i]) begin
            rdata_next = enables_reg[i];
         end else if (bus.addr == TCC_CAPTURE_VALUE_OFS[i]) begin
            rdata_next = cap[i][7:0];
            temp_next = cap[i][15:8];
            temp_load = bus.rd;
         end else if (bus.addr == TCC_COUNT_VALUE_OFS[i]) begin
            rdata_next = timer_in[i].count[7:0];
            temp_next = timer_in[i].count[15:8];
            temp_load = bus.rd;
         end else if (bus.addr == TCC_COMPARE_A_OFS[i]) begin
            rdata_next = cmp_a[i][7:0];
         end else if (bus.addr == TCC_COMPARE_A_OFS[i] + 9'h001) begin
            rdata_next = cmp_a[i][15:8];
         end else if (bus.addr == TCC_COMPARE_B_OFS[i]) begin
            rdata_next = cmp_b[i][7:0];
         end else if (bus.addr == TCC_COMPARE_B_OFS[i] + 9'h001) begin
            rdata_next = cmp_b[i][15:8];
         end else if (bus.addr == TCC_COMPARE_C_OFS[i]) begin
            rdata_next = cmp_c[i][7:0];
         end else if (bus.addr == TCC_COMPARE_C_OFS[i] + 9'h001) begin
            rdata_next = cmp_c[i][15:8];
         end else if (bus.addr == TCC_CAPTURE_VALUE_OFS[i] + 9'h001
                      || bus.addr == TCC_COUNT_VALUE_OFS[i] + 9'h001) begin
            rdata_next = temp_reg;
         end
      end
   end

   // among writes only the high byte of a 16-bit word stages the shared byte, so an
   // 8-bit register write between the two halves cannot corrupt it
   always_comb begin
      temp_stage = 1'b0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         if (bus.addr == TCC_COUNT_VALUE_OFS[i] + 9'h001
             || bus.addr == TCC_CAPTURE_VALUE_OFS[i] + 9'h001
             || bus.addr == TCC_COMPARE_A_OFS[i] + 9'h001
             || bus.addr == TCC_COMPARE_B_OFS[i] + 9'h001
             || bus.addr == TCC_COMPARE_C_OFS[i] + 9'h001) begin
            temp_stage = bus.wr;
         end
      end
   end

   // shared high byte: high-byte writes stage it for any 16-bit word
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         temp_reg <= TCC_BYTE_RESET;
      end else if (temp_stage) begin
         temp_reg <= bus.wdata;
      end else if (temp_load) begin
         temp_reg <= temp_next;
      end
   end

   // read data is registered: valid the edge after rd
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata <= TCC_BYTE_RESET;
      end else if (bus.rd) begin
         rdata <= rdata_next;
      end
   end
endmodule

// ### rtl/tcc_channel.sv
`timescale 1ns/100ps
// one timer's compare/capture datapath and flag set terms
module tcc_channel (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire tcc_pkg::tcc_timer_in_t tin,
   input wire logic [2:0] cmp_load,
   input wire logic cap_load,
   input wire logic [15:0] load_word,
   input wire logic [2:0] force_strobe,
   output logic [15:0] cmp_a,
   output logic [15:0] cmp_b,
   output logic [15:0] cmp_c,
   output logic [15:0] cap,
   output logic [5:0] flag_set,
   output logic [2:0] wave_toggle
);
   import tcc_pkg::*;
   logic [15:0] cmp_reg [3];
   logic [2:0] match_reg;
   logic block_reg;

   assign cmp_a = cmp_reg[0];
   assign cmp_b = cmp_reg[1];
   assign cmp_c = cmp_reg[2];

   // compare values, loaded as a whole word
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (sys_rst) begin
            cmp_reg[i] <= TCC_WORD_RESET;
         end else if (cmp_load[i]) begin
            cmp_reg[i] <= load_word;
         end
      end
   end

   // a counter write blocks matches on the following timer tick
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         block_reg <= 1'b0;
      end else if (tin.count_written) begin
         block_reg <= 1'b1;
      end else if (tin.tick) begin
         block_reg <= 1'b0;
      end
   end

   // match is registered, so the flag lands one timer tick later
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         match_reg <= 3'h0;
      end else if (tin.tick) begin
         for (int i = 0; i < 3; i++) begin
            match_reg[i] <= (tin.count == cmp_reg[i]) && !block_reg;
         end
      end
   end

   // capture copies the counter on an event
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cap <= TCC_WORD_RESET;
      end else if (tin.capture_event) begin
         cap <= tin.count;
      end else if (cap_load) begin
         cap <= load_word;
      end
   end

   // flag set terms; force strobes reach only the waveform path
   always_comb begin
      flag_set = 6'h00;
      flag_set[TCC_BIT_COMPARE_A] = tin.tick && match_reg[0];
      flag_set[TCC_BIT_COMPARE_B] = tin.tick && match_reg[1];
      flag_set[TCC_BIT_COMPARE_C] = tin.tick && match_reg[2];
      flag_set[TCC_BIT_OVERFLOW] = tin.overflow_event;
      flag_set[TCC_BIT_CAPTURE] = tin.capture_event
         || (tin.capture_is_top && tin.tick
             && tin.count == cap);
      wave_toggle = (match_reg & {3{tin.tick}}) | force_strobe;
   end
endmodule
